/* rtl/eus_data_path.sv */
// Register file and character data path of the extended serial unit.
// Assumes a shifter on the same clock delivers and accepts whole characters.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module eus_data_path (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [eus_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [eus_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rx_char_valid,
	input wire logic [eus_pkg::CHAR_W-1:0] rx_char_raw,
	input wire logic rx_parity_bit,
	input wire logic rx_frame_err,
	input wire logic rx_manch_err,
	input wire logic rx_long_seen,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [eus_pkg::CHAR_W-1:0] tx_char,
	output logic [eus_pkg::BITS_W-1:0] tx_char_bits,
	output logic [1:0] tx_parity_mode,
	output logic manchester_select,
	output logic [eus_pkg::BITS_W-1:0] rx_char_bits,
	output logic rx_auto_len
);
	// Bus slave state
	logic aw_held_r, w_held_r, bvalid_r, awready_r, wready_r, arready_r, rvalid_r;
	logic [eus_pkg::ADDR_W-1:0] waddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	// Registers
	logic [7:0] char_size_config_r, tx_high_r, rx_low_r, rx_high_r;
	logic manch_r, tx_ninth_r, rx_ninth_r;
	logic [1:0] par_mode_r;
	logic rxc_r, fe_r, dor_r, pe_r, fem_r, long_r;
	logic tx_valid_r;
	logic [eus_pkg::CHAR_W-1:0] tx_char_r;
	logic [eus_pkg::BITS_W-1:0] tx_bits_r, rx_bits_r;
	logic rx_auto_r;
	logic [1:0] tx_par_r;

	// Bus decode
	logic aw_take, w_take, aw_held_nxt, w_held_nxt, do_write, bvalid_nxt;
	logic ar_take, rvalid_nxt, wr_hit, rd_hit;
	logic wr_low, wr_high, wr_size, wr_ctl;
	logic rd_low;
	logic [31:0] rd_val;

	assign aw_take = awvalid && awready_r;
	assign w_take = wvalid && wready_r;
	assign aw_held_nxt = (aw_held_r || aw_take) && !do_write;
	assign w_held_nxt = (w_held_r || w_take) && !do_write;
	assign do_write = aw_held_r && w_held_r && !bvalid_r;
	assign bvalid_nxt = do_write || (bvalid_r && !bready);
	assign ar_take = arvalid && arready_r;
	assign rvalid_nxt = ar_take || (rvalid_r && !rready);

	assign wr_hit = (waddr_r == eus_pkg::ADDR_DATA_LOW) || (waddr_r == eus_pkg::ADDR_DATA_HIGH)
		|| (waddr_r == eus_pkg::ADDR_CHAR_SIZE) || (waddr_r == eus_pkg::ADDR_CONTROL)
		|| (waddr_r == eus_pkg::ADDR_STATUS_A) || (waddr_r == eus_pkg::ADDR_EXT_STATUS_C);
	assign wr_low = do_write && wlane_r && (waddr_r == eus_pkg::ADDR_DATA_LOW);
	assign wr_high = do_write && wlane_r && (waddr_r == eus_pkg::ADDR_DATA_HIGH);
	assign wr_size = do_write && wlane_r && (waddr_r == eus_pkg::ADDR_CHAR_SIZE);
	assign wr_ctl = do_write && wlane_r && (waddr_r == eus_pkg::ADDR_CONTROL);
	assign rd_hit = (araddr == eus_pkg::ADDR_DATA_LOW) || (araddr == eus_pkg::ADDR_DATA_HIGH)
		|| (araddr == eus_pkg::ADDR_CHAR_SIZE) || (araddr == eus_pkg::ADDR_CONTROL)
		|| (araddr == eus_pkg::ADDR_STATUS_A) || (araddr == eus_pkg::ADDR_EXT_STATUS_C);
	assign rd_low = ar_take && (araddr == eus_pkg::ADDR_DATA_LOW);

	// Size decoders for both directions
	eus_size_if tx_sz ();
	eus_size_if rx_sz ();
	eus_size_dec u_tx_dec (
		.sz(tx_sz.dec)
	);
	eus_size_dec u_rx_dec (
		.sz(rx_sz.dec)
	);
	// Transmit field [7:4], receive field [3:0]
	assign tx_sz.code = char_size_config_r[eus_pkg::TXS_MSB:eus_pkg::TXS_LSB];

	logic [eus_pkg::CHAR_W-1:0] rx_data;
	logic rx_par_err, rx_long;
	eus_rx_map u_rx_map (
		.sz(rx_sz.user),
		.size_code(char_size_config_r[eus_pkg::RXS_MSB:eus_pkg::RXS_LSB]),
		.raw(rx_char_raw),
		.parity_bit(rx_parity_bit),
		.parity_mode(par_mode_r),
		.manch(manch_r),
		.long_seen(rx_long_seen),
		.data(rx_data),
		.parity_err(rx_par_err),
		.long_frame(rx_long)
	);

	// Receive buffer: a read of the low byte frees it, arrival wins over the clear
	logic rx_load, rx_lost, rx_free;
	assign rx_free = !rxc_r || rd_low;
	assign rx_load = rx_char_valid && rx_free;
	assign rx_lost = rx_char_valid && !rx_free;

	// Transmit character assembly; unused bits are dropped by the mask
	logic [eus_pkg::CHAR_W-1:0] tx_asm;
	logic tx_sev;
	assign tx_sev = (tx_sz.nbits == eus_pkg::BITS_SEVENTEEN);
	assign tx_asm = {tx_ninth_r && tx_sev, tx_high_r, wbyte_r} & tx_sz.mask;

	// Read mux
	always_comb begin
		rd_val = 32'h00000000;
		if (araddr == eus_pkg::ADDR_DATA_LOW) begin
			rd_val[7:0] = rx_low_r;
		end else if (araddr == eus_pkg::ADDR_DATA_HIGH) begin
			rd_val[7:0] = rx_high_r;
		end else if (araddr == eus_pkg::ADDR_CHAR_SIZE) begin
			rd_val[7:0] = char_size_config_r;
		end else if (araddr == eus_pkg::ADDR_STATUS_A) begin
			rd_val[eus_pkg::STA_RXC] = rxc_r;
			rd_val[eus_pkg::STA_TXE] = !tx_valid_r;
			rd_val[eus_pkg::STA_FE] = fe_r;
			rd_val[eus_pkg::STA_DOR] = dor_r;
			rd_val[eus_pkg::STA_PE] = pe_r;
		end else if (araddr == eus_pkg::ADDR_CONTROL) begin
			rd_val[eus_pkg::CTL_MANCH] = manch_r;
			rd_val[eus_pkg::CTL_PAR_MSB:eus_pkg::CTL_PAR_LSB] = par_mode_r;
			rd_val[eus_pkg::CTL_TX_NINTH] = tx_ninth_r;
			rd_val[eus_pkg::CTL_RX_NINTH] = rx_ninth_r;
		end else if (araddr == eus_pkg::ADDR_EXT_STATUS_C) begin
			rd_val[eus_pkg::EXC_FEM] = fem_r;
			rd_val[eus_pkg::EXC_LONG] = long_r;
		end
	end

	// Bus handshake registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= eus_pkg::RESP_OKAY;
			waddr_r <= eus_pkg::ADDR_DATA_LOW;
			wbyte_r <= eus_pkg::BYTE_ZERO;
			wlane_r <= 1'b0;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= eus_pkg::RESP_OKAY;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awready_r <= !aw_held_nxt && !bvalid_nxt;
			wready_r <= !w_held_nxt && !bvalid_nxt;
			bvalid_r <= bvalid_nxt;
			arready_r <= !rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (aw_take) begin
				waddr_r <= awaddr;
			end
			if (w_take) begin
				wbyte_r <= wdata[7:0];
				wlane_r <= wstrb[0];
			end
			if (do_write) begin
				bresp_r <= wr_hit ? eus_pkg::RESP_OKAY : eus_pkg::RESP_SLVERR;
			end
			if (ar_take) begin
				rdata_r <= rd_val;
				rresp_r <= rd_hit ? eus_pkg::RESP_OKAY : eus_pkg::RESP_SLVERR;
			end
		end
	end

	// Next control values, so derived outputs switch together with the control register
	logic manch_nxt;
	logic [1:0] par_mode_nxt;
	assign manch_nxt = wr_ctl ? wbyte_r[eus_pkg::CTL_MANCH] : manch_r;
	assign par_mode_nxt = wr_ctl ? wbyte_r[eus_pkg::CTL_PAR_MSB:eus_pkg::CTL_PAR_LSB]
		: par_mode_r;

	// Configuration and transmit side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			char_size_config_r <= eus_pkg::CHAR_SIZE_RESET;
			manch_r <= 1'b0;
			par_mode_r <= eus_pkg::PAR_NONE;
			tx_ninth_r <= 1'b0;
			tx_high_r <= eus_pkg::BYTE_ZERO;
			tx_valid_r <= 1'b0;
			tx_char_r <= '0;
		end else begin
			if (wr_size) begin
				char_size_config_r <= wbyte_r;
			end
			if (wr_ctl) begin
				manch_r <= wbyte_r[eus_pkg::CTL_MANCH];
				par_mode_r <= wbyte_r[eus_pkg::CTL_PAR_MSB:eus_pkg::CTL_PAR_LSB];
				tx_ninth_r <= wbyte_r[eus_pkg::CTL_TX_NINTH];
			end
			if (wr_high) begin
				tx_high_r <= wbyte_r;
			end
			if (wr_low) begin
				tx_char_r <= tx_asm;
				tx_valid_r <= 1'b1;
			end else if (tx_ready) begin
				tx_valid_r <= 1'b0;
			end
		end
	end

	// Decoded sizes and parity toward the shifter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_bits_r <= eus_pkg::BITS_BYTE;
			rx_bits_r <= eus_pkg::BITS_BYTE;
			rx_auto_r <= 1'b0;
			tx_par_r <= eus_pkg::PAR_NONE;
		end else begin
			tx_bits_r <= tx_sz.nbits;
			rx_bits_r <= rx_sz.nbits;
			rx_auto_r <= rx_sz.auto_len && manch_nxt;
			tx_par_r <= manch_nxt ? eus_pkg::PAR_NONE : par_mode_nxt;
		end
	end

	// Receive buffer and error flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_low_r <= eus_pkg::BYTE_ZERO;
			rx_high_r <= eus_pkg::BYTE_ZERO;
			rx_ninth_r <= 1'b0;
			rxc_r <= 1'b0;
			fe_r <= 1'b0;
			pe_r <= 1'b0;
			fem_r <= 1'b0;
			long_r <= 1'b0;
			dor_r <= 1'b0;
		end else begin
			if (rx_load) begin
				rx_low_r <= rx_data[7:0];
				rx_high_r <= rx_data[15:8];
				rx_ninth_r <= rx_data[16];
				rxc_r <= 1'b1;
				fe_r <= rx_frame_err && !manch_r;
				pe_r <= rx_par_err;
				fem_r <= rx_manch_err && manch_r;
				long_r <= rx_long;
			end else if (rd_low) begin
				rxc_r <= 1'b0;
				fe_r <= 1'b0;
				pe_r <= 1'b0;
				fem_r <= 1'b0;
				long_r <= 1'b0;
			end
			if (rx_lost) begin
				dor_r <= 1'b1;
			end else if (rd_low) begin
				dor_r <= 1'b0;
			end
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign tx_valid = tx_valid_r;
	assign tx_char = tx_char_r;
	assign tx_char_bits = tx_bits_r;
	assign tx_parity_mode = tx_par_r;
	assign manchester_select = manch_r;
	assign rx_char_bits = rx_bits_r;
	assign rx_auto_len = rx_auto_r;
endmodule // eus_data_path
`default_nettype wire

/* rtl/eus_pkg.sv */
// Constants shared by the extended serial data path.
// Assumes AXI4-Lite register access with 32-bit data on one clock.
package eus_pkg;
	localparam int ADDR_W = 5;
	localparam int CHAR_W = 17;
	localparam int BITS_W = 5;
	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_DATA_LOW = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_DATA_HIGH = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_CHAR_SIZE = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS_A = 5'h0C;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_EXT_STATUS_C = 5'h14;
	// Reset values
	localparam logic [7:0] CHAR_SIZE_RESET = 8'h33;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Character size field positions
	localparam int TXS_MSB = 7;
	localparam int TXS_LSB = 4;
	localparam int RXS_MSB = 3;
	localparam int RXS_LSB = 0;
	// Control register bits
	localparam int CTL_MANCH = 0;
	localparam int CTL_PAR_LSB = 1;
	localparam int CTL_PAR_MSB = 2;
	localparam int CTL_TX_NINTH = 3;
	localparam int CTL_RX_NINTH = 4;
	// Standard status A bits
	localparam int STA_RXC = 7;
	localparam int STA_TXE = 5;
	localparam int STA_FE = 4;
	localparam int STA_DOR = 3;
	localparam int STA_PE = 2;
	// Extended status C bits
	localparam int EXC_FEM = 3;
	localparam int EXC_LONG = 2;
	// Size codes
	localparam int SZ_WIDE_BIT = 3;
	localparam logic [3:0] SZ_NINE = 4'h7;
	localparam logic [3:0] SZ_AUTO = 4'hE;
	localparam logic [3:0] SZ_SEVENTEEN = 4'hF;
	localparam logic [BITS_W-1:0] BITS_SHORT_BASE = 5'h05;
	localparam logic [BITS_W-1:0] BITS_WIDE_BASE = 5'h0D;
	localparam logic [BITS_W-1:0] BITS_NINE = 5'h09;
	localparam logic [BITS_W-1:0] BITS_AUTO = 5'h10;
	localparam logic [BITS_W-1:0] BITS_SEVENTEEN = 5'h11;
	localparam logic [BITS_W-1:0] BITS_BYTE = 5'h08;
	localparam logic [CHAR_W-1:0] MASK_FULL = 17'h1FFFF;
	localparam logic [CHAR_W-1:0] MASK_ONE = 17'h00001;
	// Parity mode, upper bit enables, lower bit selects odd
	localparam logic [1:0] PAR_NONE = 2'h0;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/eus_rx_map.sv */
// Trims a received character to its size and checks its parity.
// Assumes raw bits arrive right-aligned from the receive shifter.
`timescale 1ns/1ps
`default_nettype none
module eus_rx_map (
	eus_size_if.user sz,
	input wire logic [3:0] size_code,
	input wire logic [eus_pkg::CHAR_W-1:0] raw,
	input wire logic parity_bit,
	input wire logic [1:0] parity_mode,
	input wire logic manch,
	input wire logic long_seen,
	output logic [eus_pkg::CHAR_W-1:0] data,
	output logic parity_err,
	output logic long_frame
);
	logic take17_w;
	logic par_en_w;

	assign sz.code = size_code;
	assign long_frame = sz.auto_len && manch && long_seen;
	assign take17_w = (sz.nbits == eus_pkg::BITS_SEVENTEEN) || long_frame;
	// Unused upper bits come back as zero
	assign data = raw & (take17_w ? eus_pkg::MASK_FULL : sz.mask);
	// Parity only on level-encoded frames
	assign par_en_w = parity_mode[1] && !manch;
	assign parity_err = par_en_w && ((^data) ^ parity_bit ^ parity_mode[0]);
endmodule // eus_rx_map
`default_nettype wire

/* rtl/eus_size_dec.sv */
// Decodes a character size code into a bit count and a data mask.
// Assumes reserved codes are never programmed; they decode as 8 bits.
`timescale 1ns/1ps
`default_nettype none
module eus_size_dec (
	eus_size_if.dec sz
);
	logic [eus_pkg::BITS_W-1:0] nbits_w;
	logic [eus_pkg::CHAR_W-1:0] ones_w;

	always_comb begin
		if (sz.code == eus_pkg::SZ_SEVENTEEN) begin
			nbits_w = eus_pkg::BITS_SEVENTEEN;
		end else if (sz.code == eus_pkg::SZ_AUTO) begin
			nbits_w = eus_pkg::BITS_AUTO;
		end else if (sz.code == eus_pkg::SZ_NINE) begin
			nbits_w = eus_pkg::BITS_NINE;
		end else if (sz.code[eus_pkg::SZ_WIDE_BIT] && !sz.code[2]) begin
			nbits_w = eus_pkg::BITS_WIDE_BASE + {3'h0, sz.code[1:0]};
		end else if (!sz.code[eus_pkg::SZ_WIDE_BIT] && !sz.code[2]) begin
			nbits_w = eus_pkg::BITS_SHORT_BASE + {3'h0, sz.code[1:0]};
		end else begin
			nbits_w = eus_pkg::BITS_BYTE;
		end
	end

	assign ones_w = eus_pkg::MASK_ONE << nbits_w;
	assign sz.nbits = nbits_w;
	assign sz.mask = (nbits_w == eus_pkg::BITS_SEVENTEEN) ? eus_pkg::MASK_FULL
		: ones_w - eus_pkg::MASK_ONE;
	assign sz.auto_len = (sz.code == eus_pkg::SZ_AUTO);
endmodule // eus_size_dec
`default_nettype wire

/* rtl/eus_size_if.sv */
// Carries a character size code and its decoded length and mask.
// Assumes one decoder and one user per instance.
`timescale 1ns/1ps
`default_nettype none
interface eus_size_if;
	logic [3:0] code;
	logic [eus_pkg::BITS_W-1:0] nbits;
	logic [eus_pkg::CHAR_W-1:0] mask;
	logic auto_len;
	modport dec (input code, output nbits, output mask, output auto_len);
	modport user (output code, input nbits, input mask, input auto_len);
endinterface
`default_nettype wire

/* verif/eus_data_path_monitor.sv */
// Port-level checker of the extended serial data path.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module eus_data_path_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [eus_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic tx_ready,
	input wire logic tx_valid,
	input wire logic [eus_pkg::CHAR_W-1:0] tx_char,
	input wire logic [eus_pkg::BITS_W-1:0] tx_char_bits,
	input wire logic [1:0] tx_parity_mode,
	input wire logic manchester_select,
	input wire logic [eus_pkg::BITS_W-1:0] rx_char_bits,
	input wire logic rx_auto_len
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [eus_pkg::ADDR_W-1:0] aw_r;
	logic ws_r;
	// Last write address and byte enable taken
	always_ff @(posedge aclk) begin
		if (awvalid && awready) aw_r <= awaddr;
		if (wvalid && wready) ws_r <= wstrb[0];
	end
	a_tx_start: assert property ($rose(bvalid) && aw_r == eus_pkg::ADDR_DATA_LOW && ws_r
		|-> tx_valid) else $error("low byte write did not start a character");
	a_high_silent: assert property ($rose(bvalid) && aw_r != eus_pkg::ADDR_DATA_LOW
		&& !$past(tx_valid) |-> !tx_valid) else $error("character started without low write");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
		else $error("pending character changed before taken");
	a_tx_drop: assert property (tx_valid && tx_ready |=> !tx_valid || $rose(bvalid))
		else $error("character offered again after taken");
	a_tx_mask: assert property (tx_valid |-> (tx_char >> tx_char_bits) == '0)
		else $error("unused character bits sent");
	a_tx_bits: assert property (tx_valid |-> tx_char_bits inside {[5'h05:5'h09], [5'h0D:5'h11]})
		else $error("transmit size out of range");
	a_manch_parity: assert property (manchester_select |-> tx_parity_mode == eus_pkg::PAR_NONE)
		else $error("parity active in Manchester mode");
	a_auto_len: assert property (rx_auto_len |-> manchester_select
		&& rx_char_bits == eus_pkg::BITS_AUTO) else $error("auto length outside Manchester mode");
	a_rd_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered next cycle");
	a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before taken");
endmodule // eus_data_path_monitor
bind eus_data_path eus_data_path_monitor u_mon (.*);
`default_nettype wire

/* verif/eus_data_path_tb.sv */
// Self-checking bench of the extended serial data path.
// Assumes the checker is bound in and the line model stands on the far side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module eus_data_path_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [eus_pkg::ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, tx_valid, manchester_select, rx_auto_len;
	logic [1:0] bresp, rresp, tx_parity_mode;
	logic [31:0] rdata;
	logic rx_char_valid, rx_parity_bit, rx_frame_err, rx_manch_err, rx_long_seen, tx_ready;
	logic [eus_pkg::CHAR_W-1:0] rx_char_raw, tx_char;
	logic [eus_pkg::BITS_W-1:0] tx_char_bits, rx_char_bits;
	int mismatches = 0, n_tests = 0;
	logic [15:0] lf = 16'hD5D1;
	logic [21:0] exp_q [$];
	logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hF};
	eus_data_path u_dut (.*);
	eus_line_model u_line (.*);
	always #10 aclk = ~aclk;
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction
	function automatic int nb(input logic [3:0] c);
		if (c == 4'h7) return 9;
		if (c < 4'hC) return c + 5;
		return c == 4'hE ? 16 : 17;
	endfunction
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		`CHK("bresp", er, bresp)
		bready <= 1'b0;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [7:0] k, input logic [7:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		`CHK("rdata", e, rdata[7:0] & k)
		`CHK("rresp", (a > 5'h14) ? eus_pkg::RESP_SLVERR : eus_pkg::RESP_OKAY, rresp)
		rready <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		end_of_test();
	end
	initial begin
		logic [3:0] c;
		logic [31:0] v, w;
		int n, m;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rchk(eus_pkg::ADDR_CHAR_SIZE, 8'hFF, 8'h33);
		rchk(5'h18, 8'hFF, 8'h00);
		wr(5'h1C, 8'h55, eus_pkg::RESP_SLVERR);
		foreach (codes[i]) begin
			c = codes[i];
			n = nb(c);
			m = (1 << n) - 1;
			v = {rnd(), rnd()};
			w = {rnd(), rnd()};
			u_line.stall = v[18:17];
			wr(eus_pkg::ADDR_CHAR_SIZE, {c, c}, eus_pkg::RESP_OKAY);
			@(posedge aclk);
			`CHK("rx bits", n[4:0], rx_char_bits)
			wr(eus_pkg::ADDR_CONTROL, {4'h0, v[16], 3'h0}, eus_pkg::RESP_OKAY);
			wr(eus_pkg::ADDR_DATA_HIGH, v[15:8], eus_pkg::RESP_OKAY);
			repeat (4) @(posedge aclk);
			`CHK("tx early", 0, u_line.got.size())
			wr(eus_pkg::ADDR_DATA_LOW, v[7:0], eus_pkg::RESP_OKAY);
			exp_q.push_back({n[4:0], v[16:0] & m[16:0]});
			repeat (20) if (u_line.got.size() == 0) @(posedge aclk);
			`CHK("tx char", exp_q[0], u_line.got[0])
			exp_q.delete();
			u_line.got.delete();
			u_line.send(w[16:0], 1'b0, 1'b0, 1'b0, 1'b0);
			rchk(eus_pkg::ADDR_STATUS_A, 8'h9C, 8'h80);
			rchk(eus_pkg::ADDR_CONTROL, 8'h10, {3'h0, (n == 17 && w[16]), 4'h0});
			rchk(eus_pkg::ADDR_DATA_HIGH, 8'hFF, w[15:8] & m[15:8]);
			rchk(eus_pkg::ADDR_DATA_LOW, 8'hFF, w[7:0] & m[7:0]);
			rchk(eus_pkg::ADDR_STATUS_A, 8'h80, 8'h00);
		end
		wr(eus_pkg::ADDR_CHAR_SIZE, 8'h33, eus_pkg::RESP_OKAY);
		wr(eus_pkg::ADDR_CONTROL, 8'h04, eus_pkg::RESP_OKAY);
		@(posedge aclk);
		`CHK("tx parity", 2'h2, tx_parity_mode)
		u_line.send(w[16:0], ^w[7:0], 1'b0, 1'b0, 1'b0);
		rchk(eus_pkg::ADDR_STATUS_A, 8'h9C, 8'h80);
		rchk(eus_pkg::ADDR_DATA_LOW, 8'hFF, w[7:0]);
		u_line.send(w[16:0], ~^w[7:0], 1'b1, 1'b0, 1'b0);
		u_line.send(~w[16:0], 1'b0, 1'b0, 1'b0, 1'b0);
		rchk(eus_pkg::ADDR_STATUS_A, 8'h9C, 8'h9C);
		rchk(eus_pkg::ADDR_DATA_LOW, 8'hFF, w[7:0]);
		rchk(eus_pkg::ADDR_STATUS_A, 8'h9C, 8'h00);
		wr(eus_pkg::ADDR_CHAR_SIZE, 8'h3E, eus_pkg::RESP_OKAY);
		wr(eus_pkg::ADDR_CONTROL, 8'h05, eus_pkg::RESP_OKAY);
		@(posedge aclk);
		`CHK("tx parity", 2'h0, tx_parity_mode)
		`CHK("manch sel", 1'h1, manchester_select)
		`CHK("auto len", 1'h1, rx_auto_len)
		u_line.send(w[16:0], ~^w[7:0], 1'b1, 1'b1, 1'b1);
		u_line.send(~w[16:0], 1'b0, 1'b0, 1'b0, 1'b0);
		rchk(eus_pkg::ADDR_STATUS_A, 8'h9C, 8'h88);
		rchk(eus_pkg::ADDR_EXT_STATUS_C, 8'h0C, 8'h0C);
		rchk(eus_pkg::ADDR_CONTROL, 8'h10, {3'h0, w[16], 4'h0});
		rchk(eus_pkg::ADDR_DATA_HIGH, 8'hFF, w[15:8]);
		rchk(eus_pkg::ADDR_DATA_LOW, 8'hFF, w[7:0]);
		u_line.send(~w[16:0], 1'b0, 1'b0, 1'b0, 1'b0);
		rchk(eus_pkg::ADDR_EXT_STATUS_C, 8'h0C, 8'h00);
		rchk(eus_pkg::ADDR_CONTROL, 8'h10, 8'h00);
		rchk(eus_pkg::ADDR_DATA_LOW, 8'hFF, ~w[7:0]);
		end_of_test();
	end
endmodule // eus_data_path_tb
`default_nettype wire

/* verif/eus_line_model.sv */
// Far-side serial transceiver: hands in received characters, takes sent ones.
// Assumes the bench calls send and sets stall; shares the design clock.
`timescale 1ns/1ps
`default_nettype none
module eus_line_model (
	input wire logic aclk,
	output logic rx_char_valid,
	output logic [eus_pkg::CHAR_W-1:0] rx_char_raw,
	output logic rx_parity_bit,
	output logic rx_frame_err,
	output logic rx_manch_err,
	output logic rx_long_seen,
	output logic tx_ready,
	input wire logic tx_valid,
	input wire logic [eus_pkg::CHAR_W-1:0] tx_char,
	input wire logic [eus_pkg::BITS_W-1:0] tx_char_bits
);
	int stall = 0;
	int cnt = 0;
	logic [21:0] got [$];
	initial begin
		rx_char_valid = 1'b0;
		{rx_char_raw, rx_parity_bit, rx_frame_err, rx_manch_err, rx_long_seen} = '0;
		tx_ready = 1'b0;
	end
	// One-cycle character pulse, then the lines show the inverse
	task automatic send(input logic [16:0] r, input logic p, fe, me, ln);
		@(posedge aclk);
		{rx_char_raw, rx_parity_bit, rx_frame_err, rx_manch_err, rx_long_seen} <= {r, p, fe, me, ln};
		rx_char_valid <= 1'b1;
		@(posedge aclk);
		{rx_char_raw, rx_parity_bit, rx_frame_err, rx_manch_err, rx_long_seen} <= ~{r, p, fe, me, ln};
		rx_char_valid <= 1'b0;
	endtask
	// Takes a waiting character after stall cycles
	always @(posedge aclk) begin
		if (tx_valid && tx_ready) begin
			got.push_back({tx_char_bits, tx_char});
			tx_ready <= 1'b0;
			cnt = 0;
		end else if (tx_valid && cnt >= stall) begin
			tx_ready <= 1'b1;
		end else if (tx_valid) begin
			cnt++;
		end
	end
endmodule // eus_line_model
`default_nettype wire
